// ---- pkg/cfg_map_pkg.sv ----
// Purpose: constants and types for the shadowed configuration register bank
// Assumes: byte-wide registers, 8-bit address space, serial port front end
// Notes:   defaults other than output format are plain zero
package cfg_map_pkg;

  localparam int          INSTR_BITS         = 16;
  localparam int          WORD_BITS          = 8;
  localparam logic [7:0]  CHIP_CFG_FIRST     = 8'h00;
  localparam logic [7:0]  CHIP_CFG_LAST      = 8'h02;
  localparam logic [7:0]  FUNC_FIRST         = 8'h08;
  localparam logic [7:0]  FUNC_LAST          = 8'hA8;
  localparam logic [7:0]  ADDR_CHIP_ID       = 8'h01;
  localparam logic [7:0]  ADDR_OUTPUT_FORMAT = 8'h14;
  localparam logic [7:0]  ADDR_XFER          = 8'hFF;
  localparam logic [7:0]  ADDR_SHADOW_A      = 8'h09;
  localparam logic [7:0]  ADDR_SHADOW_B      = 8'h0B;
  localparam logic [7:0]  ADDR_SHADOW_C      = 8'h18;
  localparam logic [7:0]  SHADOW_RANGE_FIRST = 8'h3A;
  localparam logic [7:0]  SHADOW_RANGE_LAST  = 8'h4C;
  localparam logic [7:0]  OPEN_EXAMPLE       = 8'h13;
  localparam logic [7:0]  RST_OUTPUT_FORMAT  = 8'h01;
  localparam logic [7:0]  RST_DEFAULT        = 8'h00;
  localparam logic [7:0]  XFER_CMD           = 8'h01;
  localparam logic [7:0]  CHIP_ID_VALUE      = 8'h5A; // arbitrary value
  localparam logic [4:0]  BIT_CNT_RST        = 5'h00;

  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } instr_t;

  typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_IDLE} phase_t;

endpackage : cfg_map_pkg

// ---- src/cfg_reg_bank.sv ----
// Purpose: byte-wide configuration register bank with shadow staging
// Assumes: serial pins sampled on I_REF_CLK, MSB first, one address per frame
// Notes:   the active copy of the whole map is exported flat on O_ACTIVE
`timescale 1ns/1ps
`default_nettype none

module cfg_reg_bank (
  input  wire logic           I_REF_CLK,
  input  wire logic           I_SRST,
  input  wire logic           I_SCLK,
  input  wire logic           I_CS_N,
  input  wire logic           I_SDIO,
  output logic                O_SDIO,
  output logic                O_SDIO_OE,
  output logic [256*8-1:0]    O_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_valid(input logic [7:0] a);
    is_valid = (a <= cfg_map_pkg::CHIP_CFG_LAST)
            || (a >= cfg_map_pkg::FUNC_FIRST && a <= cfg_map_pkg::FUNC_LAST
                && a != cfg_map_pkg::OPEN_EXAMPLE)
            || (a == cfg_map_pkg::ADDR_XFER);
  endfunction : is_valid

  function automatic logic is_shadowed(input logic [7:0] a);
    is_shadowed = (a == cfg_map_pkg::ADDR_SHADOW_A) || (a == cfg_map_pkg::ADDR_SHADOW_B)
               || (a == cfg_map_pkg::ADDR_OUTPUT_FORMAT) || (a == cfg_map_pkg::ADDR_SHADOW_C)
               || (a >= cfg_map_pkg::SHADOW_RANGE_FIRST
                   && a <= cfg_map_pkg::SHADOW_RANGE_LAST);
  endfunction : is_shadowed

  function automatic logic [7:0] default_of(input logic [7:0] a);
    if (a == cfg_map_pkg::ADDR_OUTPUT_FORMAT)
      default_of = cfg_map_pkg::RST_OUTPUT_FORMAT;
    else
      default_of = cfg_map_pkg::RST_DEFAULT;
  endfunction : default_of

  ////////////////////////////////////////////////////////////////////////////
  // pins are asynchronous to the reference clock: two flops before use
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       sclk_prev_reg;

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      // idle pin levels (deselected, clock low) so no false edge follows reset
      sync1_reg     <= 3'h4;
      sync2_reg     <= 3'h4;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg     <= {I_CS_N, I_SCLK, I_SDIO};
      sync2_reg     <= sync1_reg;
      sclk_prev_reg <= sync2_reg[1];
    end
  end

  logic cs_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_s;
  assign cs_n_s    = sync2_reg[2];
  assign sdi_s     = sync2_reg[0];
  assign sclk_rise = sync2_reg[1] & ~sclk_prev_reg;
  assign sclk_fall = ~sync2_reg[1] & sclk_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register storage: staging copy written by host, active copy drives part
  logic [7:0] stage_reg  [256];
  logic [7:0] active_reg [256];
  logic [7:0] stage_next [256];
  logic [7:0] active_next[256];

  cfg_map_pkg::phase_t phase_reg;
  cfg_map_pkg::phase_t phase_next;
  cfg_map_pkg::instr_t instr_reg;
  cfg_map_pkg::instr_t instr_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic [7:0]  rd_byte_reg;
  logic [7:0]  rd_byte_next;
  logic        sdo_reg;
  logic        sdo_next;
  logic        oe_reg;
  logic        oe_next;
  logic        xfer_reg;
  logic        xfer_next;

  function automatic logic [7:0] read_value(input logic [7:0] a,
                                            input logic [7:0] st);
    if (!is_valid(a))
      read_value = 8'h00;
    else if (a == cfg_map_pkg::ADDR_CHIP_ID)
      read_value = cfg_map_pkg::CHIP_ID_VALUE;
    else
      read_value = st;
  endfunction : read_value

  always_comb
  begin
    logic [15:0] sh;
    logic [7:0]  wa;
    sh = {shift_reg[14:0], sdi_s};
    wa = instr_reg.addr;
    phase_next   = phase_reg;
    instr_next   = instr_reg;
    shift_next   = shift_reg;
    cnt_next     = cnt_reg;
    rd_byte_next = rd_byte_reg;
    sdo_next     = sdo_reg;
    oe_next      = oe_reg;
    xfer_next    = 1'b0;
    for (int i = 0; i < 256; i++)
    begin
      stage_next[i]  = stage_reg[i];
      active_next[i] = active_reg[i];
    end
    if (xfer_reg)
    begin
      for (int i = 0; i < 256; i++)
        if (is_shadowed(i[7:0]))
          active_next[i] = stage_reg[i];
      active_next[cfg_map_pkg::ADDR_XFER] = cfg_map_pkg::RST_DEFAULT;
    end
    if (cs_n_s)
    begin
      phase_next = cfg_map_pkg::ST_INSTR;
      cnt_next   = cfg_map_pkg::BIT_CNT_RST;
      oe_next    = 1'b0;
    end
    else if (sclk_rise && phase_reg != cfg_map_pkg::ST_IDLE)
    begin
      shift_next = sh;
      cnt_next   = cnt_reg + 5'h01;
      if (phase_reg == cfg_map_pkg::ST_INSTR && cnt_reg == 5'(cfg_map_pkg::INSTR_BITS - 1))
      begin
        // single-byte access: length bits are accepted but not honoured
        instr_next.rd   = sh[15];
        instr_next.addr = sh[7:0];
        cnt_next        = cfg_map_pkg::BIT_CNT_RST;
        phase_next      = cfg_map_pkg::ST_DATA;
        rd_byte_next    = read_value(sh[7:0], stage_reg[sh[7:0]]);
      end
      else if (phase_reg == cfg_map_pkg::ST_DATA && cnt_reg == 5'(cfg_map_pkg::WORD_BITS - 1))
      begin
        phase_next = cfg_map_pkg::ST_IDLE;
        if (!instr_reg.rd && is_valid(wa) && wa != cfg_map_pkg::ADDR_CHIP_ID)
        begin
          if (wa == cfg_map_pkg::ADDR_XFER)
          begin
            xfer_next = (sh[7:0] == cfg_map_pkg::XFER_CMD);
            // transfer bit shows in the active byte for the one copy cycle
            if (sh[7:0] == cfg_map_pkg::XFER_CMD)
              active_next[wa] = cfg_map_pkg::XFER_CMD;
          end
          else
          begin
            stage_next[wa] = sh[7:0];
            if (!is_shadowed(wa))
              active_next[wa] = sh[7:0];
          end
        end
      end
    end
    else if (sclk_fall && phase_reg == cfg_map_pkg::ST_DATA && instr_reg.rd)
    begin
      oe_next      = 1'b1;
      sdo_next     = rd_byte_reg[7];
      rd_byte_next = {rd_byte_reg[6:0], 1'b0};
    end
    else if (phase_reg == cfg_map_pkg::ST_IDLE)
      oe_next = 1'b0;
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      for (int i = 0; i < 256; i++)
      begin
        stage_reg[i]  <= default_of(i[7:0]);
        active_reg[i] <= default_of(i[7:0]);
      end
      phase_reg   <= cfg_map_pkg::ST_INSTR;
      instr_reg   <= '0;
      shift_reg   <= 16'h0000;
      cnt_reg     <= cfg_map_pkg::BIT_CNT_RST;
      rd_byte_reg <= 8'h00;
      sdo_reg     <= 1'b0;
      oe_reg      <= 1'b0;
      xfer_reg    <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 256; i++)
      begin
        stage_reg[i]  <= stage_next[i];
        active_reg[i] <= active_next[i];
      end
      phase_reg   <= phase_next;
      instr_reg   <= instr_next;
      shift_reg   <= shift_next;
      cnt_reg     <= cnt_next;
      rd_byte_reg <= rd_byte_next;
      sdo_reg     <= sdo_next;
      oe_reg      <= oe_next;
      xfer_reg    <= xfer_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    for (int i = 0; i < 256; i++)
      O_ACTIVE[i*8 +: 8] = active_reg[i];
  end
  assign O_SDIO    = sdo_reg;
  assign O_SDIO_OE = oe_reg;

endmodule : cfg_reg_bank

`default_nettype wire

// ---- testbench/cfg_reg_bank_chk.sv ----
// Purpose: port assertions for the configuration register bank
// Assumes: active byte a sits at O_ACTIVE[a*8+:8]
// Notes:   pin sync latency is allowed for in the counts
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_bank_chk (
  input wire logic          I_REF_CLK,
  input wire logic          I_SRST,
  input wire logic          I_SCLK,
  input wire logic          I_CS_N,
  input wire logic          I_SDIO,
  input wire logic          O_SDIO,
  input wire logic          O_SDIO_OE,
  input wire logic [2047:0] O_ACTIVE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  chk_fmt_default: assert property ($fell(I_SRST) |-> O_ACTIVE[160+:8] == 8'h01)
    else $error("output format not at default after reset");
  chk_zero_default: assert property ($fell(I_SRST) |-> O_ACTIVE[72+:8] == 8'h00)
    else $error("staged register not cleared by reset");
  chk_open_zero: assert property (O_ACTIVE[152+:8] == 8'h00)
    else $error("open location holds a value");
  chk_region_edge: assert property (O_ACTIVE[1408+:8] == 8'h00)
    else $error("address past function region holds a value");
  chk_xfer_clears: assert property (O_ACTIVE[2040] |=> !O_ACTIVE[2040])
    else $error("transfer bit did not clear itself");
  chk_idle_oe: assert property (I_CS_N [*5] |-> !O_SDIO_OE)
    else $error("data pin driven while deselected");
  chk_quiet_map: assert property (I_CS_N [*8] |=> $stable(O_ACTIVE))
    else $error("active map changed with no host access");
  chk_oe_frame: assert property ($rose(O_SDIO_OE) |-> !I_CS_N && !$past(I_CS_N, 3))
    else $error("read drive started outside a frame");
endmodule : cfg_reg_bank_chk
bind cfg_reg_bank cfg_reg_bank_chk chk_u (.I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST),
  .I_SCLK(I_SCLK), .I_CS_N(I_CS_N), .I_SDIO(I_SDIO), .O_SDIO(O_SDIO),
  .O_SDIO_OE(O_SDIO_OE), .O_ACTIVE(O_ACTIVE));
`default_nettype wire

// ---- testbench/cfg_host_model.sv ----
// Purpose: serial port host driving frames into the register bank
// Assumes: 4 clk per serial clock half, MSB first, one byte per frame
// Notes:   serial clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input  wire logic i_clk,
  input  wire logic i_dev_sdio,
  input  wire logic i_dev_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdio
);
  logic host_bit;
  // released pin toggles so a stale value can never pass for read data
  assign o_sdio = i_dev_oe ? i_dev_sdio : host_bit;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    host_bit = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic frame(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                       output logic [7:0] rdat);
    logic [23:0] sh;
    sh = {rd, 7'h00, a, wd};
    o_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      host_bit = (rd && i < 8) ? ~host_bit : sh[i];
      tick(4);
      if (i < 8) rdat[i] = o_sdio;
      o_sclk = 1'b1;
      tick(4);
      o_sclk = 1'b0;
    end
    tick(4);
    o_cs_n = 1'b1;
    tick(8);
  endtask : frame
endmodule : cfg_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: register bank regression through the serial port
// Assumes: staged values read back, active copy seen on O_ACTIVE
// Notes:   expectations come from the register map only
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic          clk, srst, sclk, cs_n, sdio, dev_sdio, dev_oe;
  logic [2047:0] active;
  logic [7:0]    rv;
  int            errors, n_tests;
  cfg_reg_bank dut_u (.I_REF_CLK(clk), .I_SRST(srst), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_SDIO(sdio), .O_SDIO(dev_sdio), .O_SDIO_OE(dev_oe), .O_ACTIVE(active));
  cfg_host_model host_u (.i_clk(clk), .i_dev_sdio(dev_sdio), .i_dev_oe(dev_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask : check
  function automatic logic [7:0] act(input logic [7:0] a);
    return active[int'(a)*8+:8];
  endfunction : act
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host_u.frame(1'b0, a, d, x);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host_u.frame(1'b1, a, 8'h00, rv);
    check("read", e, rv);
  endtask : rdc
  task automatic do_reset;
    srst = 1'b1;
    host_u.tick(2);
    srst = 1'b0;
    check("fmt rst", 8'h01, act(8'h14));
    check("a09 rst", 8'h00, act(8'h09));
  endtask : do_reset
  task automatic finish_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  initial
  begin
    #400000;
    errors++;
    finish_test();
  end
  initial
  begin
    errors = 0;
    n_tests = 0;
    do_reset();
    wr(8'h09, 8'hA5);
    wr(8'h14, 8'h00);
    wr(8'h4C, 8'h81);
    check("a09 staged", 8'h00, act(8'h09));
    check("a14 staged", 8'h01, act(8'h14));
    rdc(8'h09, 8'hA5);
    wr(8'hFF, 8'h02);
    check("bad xfer", 8'h00, act(8'h4C));
    wr(8'hFF, 8'h01);
    check("a09 xfer", 8'hA5, act(8'h09));
    check("a14 xfer", 8'h00, act(8'h14));
    check("a4C xfer", 8'h81, act(8'h4C));
    check("xfer clr", 8'h00, act(8'hFF));
    rdc(8'hFF, 8'h00);
    wr(8'h08, 8'h3C);
    check("a08 direct", 8'h3C, act(8'h08));
    rdc(8'h13, 8'h00);
    rdc(8'h01, cfg_map_pkg::CHIP_ID_VALUE);
    rdc(8'hB0, 8'h00);
    do_reset();
    finish_test();
  end
endmodule : tb
`default_nettype wire
